// file: design/mcu_interrupt_controller.sv
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "irq_params.svh"
module mcu_interrupt_controller
   import irq_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        nmi_n,
   input  wire logic        port_a_irq_n,
   input  wire logic        port_b_irq_n,
   input  wire logic        port_c_irq_n,
   input  wire logic        timer_ovf_evt,
   input  wire logic        adc_done_evt,
   input  wire logic        rt_wrap_evt,
   input  wire logic        rt_compare_evt,
   input  wire logic        rt_capture_evt,
   input  wire logic        instr_end,
   input  wire logic        return_from_interrupt,
   input  wire logic        low_power_req,
   input  wire logic        flag_wr,
   input  wire logic        carry_in,
   input  wire logic        zero_in,
   output logic             skip_instr,
   output logic             stack_push,
   output logic             stack_pop,
   output logic             pc_load,
   output logic [11:0]      pc_vector,
   output flag_mode_t       flag_set_sel,
   output logic             irq_mode,
   output logic             nmi_mode,
   output logic             carry_out,
   output logic             zero_out,
   output logic             low_power_ok,
   output logic             low_power_refused,
   output logic             wake_up
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [`PIN_COUNT-1:0] pin_raw;
   logic [`PIN_COUNT-1:0] pin_level;
   logic [`PIN_COUNT-1:0] pin_fall;
   logic [`PIN_COUNT-1:0] pin_rise;

   assign pin_raw = {port_c_irq_n, port_b_irq_n, port_a_irq_n, nmi_n};

   genvar gp;
   generate
      for (gp = 0; gp < `PIN_COUNT; gp = gp + 1)
      begin : g_pin
         irq_pin_sync u_sync
         (
            .clk        (hclk),
            .rst_n      (hresetn),
            .pin        (pin_raw[gp]),
            .level      (pin_level[gp]),
            .fall_pulse (pin_fall[gp]),
            .rise_pulse (pin_rise[gp])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // registers and bus decode
   // ----------------------------------------------------------------
   logic [7:0]            interrupt_option_reg;
   logic [`EVT_COUNT-1:0] evt_mask_reg;
   logic [`EVT_COUNT-1:0] evt_flag_reg;
   logic [`EVT_COUNT-1:0] evt_flag_next;
   logic [`EVT_COUNT-1:0] evt_in;
   logic [31:0]           wr_addr_reg;
   logic                  wr_pend_reg;
   logic                  addr_valid;
   logic                  wr_option;
   logic                  wr_mask;
   logic                  wr_flag;
   logic [31:0]           rdata_next;
   logic [9:0]            status_word;
   logic                  global_irq_enable;
   logic                  src1_level_select;
   logic                  src2_rising_edge_select;

   assign addr_valid              = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
   assign wr_option               = wr_pend_reg & (wr_addr_reg == `ADDR_OPTION);
   assign wr_mask                 = wr_pend_reg & (wr_addr_reg == `ADDR_EVT_MASK);
   assign wr_flag                 = wr_pend_reg & (wr_addr_reg == `ADDR_EVT_FLAG);
   assign global_irq_enable       = interrupt_option_reg[`OPTION_ENABLE_BIT];
   assign src1_level_select       = interrupt_option_reg[`OPTION_LEVEL_BIT];
   assign src2_rising_edge_select = interrupt_option_reg[`OPTION_RISE_BIT];

   // option register is write-only, so its address reads zero
   assign rdata_next =
      (haddr == `ADDR_STATUS)   ? {22'h000000, status_word}   :
      (haddr == `ADDR_EVT_MASK) ? {27'h0000000, evt_mask_reg} :
      (haddr == `ADDR_EVT_FLAG) ? {27'h0000000, evt_flag_reg} :
      32'h00000000;

   // zero-wait slave: address phase captured, write lands in data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'h0;
         wr_addr_reg <= 32'h00000000;
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'h1;
         hresp       <= 1'h0;
      end
      else
      begin
         wr_pend_reg <= addr_valid & hwrite;
         wr_addr_reg <= haddr;
         hrdata      <= (addr_valid & ~hwrite) ? rdata_next : 32'h00000000;
         hreadyout   <= 1'h1;
         hresp       <= 1'h0;
      end
   end

   // whole-byte load only, no read-modify-write path exists
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         interrupt_option_reg <= `OPTION_RESET;
         evt_mask_reg <= `EVT_RESET;
      end
      else
      begin
         if (wr_option)
            interrupt_option_reg <= hwdata[7:0];
         if (wr_mask)
            evt_mask_reg <= hwdata[`EVT_COUNT-1:0];
      end
   end

   // ----------------------------------------------------------------
   // peripheral event flags
   // ----------------------------------------------------------------
   assign evt_in = {rt_capture_evt, rt_compare_evt, rt_wrap_evt, adc_done_evt, timer_ovf_evt};

   // write one to clear; a new event in the same cycle wins
   assign evt_flag_next = (evt_flag_reg & ~(wr_flag ? hwdata[`EVT_COUNT-1:0] : `EVT_RESET))
                          | evt_in;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         evt_flag_reg <= `EVT_RESET;
      else
         evt_flag_reg <= evt_flag_next;
   end

   // ----------------------------------------------------------------
   // request latches and levels
   // ----------------------------------------------------------------
   entry_state_t state_reg;
   entry_state_t state_next;
   source_t      src_sel_reg;
   source_t      src_pick;
   logic         nmi_latch_reg;
   logic         edge1_latch_reg;
   logic         edge2_latch_reg;
   logic         src1_prev_reg;
   logic         src1_line_n;
   logic         src1_fall;
   logic         src2_edge;
   logic         clr_step;
   logic [3:0]   req;
   logic         accept_nmi;
   logic         accept_mask;
   logic         take;
   logic         pending_enabled;
   logic         irq_active_reg;
   logic         nmi_active_reg;

   // ports a and b share source 1: either line low requests
   assign src1_line_n = pin_level[`PIN_PA] & pin_level[`PIN_PB];
   assign src1_fall   = src1_prev_reg & ~src1_line_n;
   assign src2_edge   = src2_rising_edge_select ? pin_rise[`PIN_PC] : pin_fall[`PIN_PC];
   assign clr_step    = (state_reg == ENTRY_CLEAR);

   // level sources are not stored; the requester holds the line
   assign req[0] = src1_level_select ? ~src1_line_n : edge1_latch_reg;
   assign req[1] = edge2_latch_reg;
   assign req[2] = |(evt_flag_reg[`EVT_RT_CAP:`EVT_RT_WRAP]
                   & evt_mask_reg[`EVT_RT_CAP:`EVT_RT_WRAP]);
   assign req[3] = |(evt_flag_reg[`EVT_ADC:`EVT_TMR]
                   & evt_mask_reg[`EVT_ADC:`EVT_TMR]);

   // one bit per latch: extra edges before service are simply absorbed
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nmi_latch_reg   <= 1'h0;
         edge1_latch_reg <= 1'h0;
         edge2_latch_reg <= 1'h0;
         src1_prev_reg   <= `PIN_IDLE;
      end
      else
      begin
         nmi_latch_reg   <= pin_fall[`PIN_NMI]
                            | (nmi_latch_reg & ~(clr_step & (src_sel_reg == SRC_NMI)));
         edge1_latch_reg <= (~src1_level_select & src1_fall)
                            | (edge1_latch_reg & ~(clr_step & (src_sel_reg == SRC_1)));
         edge2_latch_reg <= src2_edge
                            | (edge2_latch_reg & ~(clr_step & (src_sel_reg == SRC_2)));
         src1_prev_reg   <= src1_line_n;
      end
   end

   // ----------------------------------------------------------------
   // acceptance and priority
   // ----------------------------------------------------------------
   assign accept_nmi  = nmi_latch_reg & ~nmi_active_reg;
   assign accept_mask = global_irq_enable & (|req) & ~irq_active_reg & ~nmi_active_reg;
   assign take        = instr_end & (state_reg == ENTRY_IDLE)
                        & (accept_nmi | accept_mask);
   assign pending_enabled = nmi_latch_reg | (global_irq_enable & (|req));

   // fixed order, nothing in software can reorder it
   assign src_pick = accept_nmi ? SRC_NMI :
                     req[0]     ? SRC_1   :
                     req[1]     ? SRC_2   :
                     req[2]     ? SRC_3   : SRC_4;

   // ----------------------------------------------------------------
   // entry sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ENTRY_IDLE:    if (take) state_next = ENTRY_FLAGS;
         ENTRY_FLAGS:   state_next = ENTRY_PUSH;
         ENTRY_PUSH:    state_next = ENTRY_INHIBIT;
         ENTRY_INHIBIT: state_next = ENTRY_CLEAR;
         ENTRY_CLEAR:   state_next = ENTRY_VECTOR;
         default:       state_next = ENTRY_IDLE;
      endcase
   end

   // one step per cycle keeps the documented entry order visible
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg   <= ENTRY_IDLE;
         src_sel_reg <= SRC_NMI;
         skip_instr  <= 1'h0;
         stack_push  <= 1'h0;
         pc_load     <= 1'h0;
         pc_vector   <= `VEC_NMI;
      end
      else
      begin
         state_reg  <= state_next;
         skip_instr <= take;
         stack_push <= (state_reg == ENTRY_PUSH);
         pc_load    <= (state_reg == ENTRY_VECTOR);
         if (take)
            src_sel_reg <= src_pick;
         if (state_reg == ENTRY_VECTOR)
            pc_vector <= (src_sel_reg == SRC_NMI) ? `VEC_NMI  :
                         (src_sel_reg == SRC_1)   ? `VEC_SRC1 :
                         (src_sel_reg == SRC_2)   ? `VEC_SRC2 :
                         (src_sel_reg == SRC_3)   ? `VEC_SRC3 : `VEC_SRC4;
      end
   end

   // ----------------------------------------------------------------
   // service mode and flag-set selection
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_active_reg <= 1'h0;
         nmi_active_reg <= 1'h0;
         flag_set_sel   <= MODE_NORMAL;
         stack_pop      <= 1'h0;
      end
      else
      begin
         stack_pop <= return_from_interrupt;
         if (state_reg == ENTRY_FLAGS)
            flag_set_sel <= (src_sel_reg == SRC_NMI) ? MODE_NMI : MODE_IRQ;
         else if (return_from_interrupt & nmi_active_reg)
            flag_set_sel <= irq_active_reg ? MODE_IRQ : MODE_NORMAL;
         else if (return_from_interrupt)
            flag_set_sel <= MODE_NORMAL;
         if (state_reg == ENTRY_INHIBIT)
         begin
            if (src_sel_reg == SRC_NMI)
               nmi_active_reg <= 1'h1;
            else
               irq_active_reg <= 1'h1;
         end
         else if (return_from_interrupt & nmi_active_reg)
            nmi_active_reg <= 1'h0;
         else if (return_from_interrupt)
            irq_active_reg <= 1'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_mode <= 1'h0;
         nmi_mode <= 1'h0;
      end
      else
      begin
         irq_mode <= irq_active_reg;
         nmi_mode <= nmi_active_reg;
      end
   end

   // ----------------------------------------------------------------
   // three carry/zero sets
   // ----------------------------------------------------------------
   logic carry_set_reg [`FLAG_SETS];
   logic zero_set_reg  [`FLAG_SETS];

   // each set written only while selected, so software never saves them
   genvar gf;
   generate
      for (gf = 0; gf < `FLAG_SETS; gf = gf + 1)
      begin : g_flags
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               carry_set_reg[gf] <= 1'h0;
               zero_set_reg[gf]  <= 1'h0;
            end
            else if (flag_wr & (flag_set_sel == flag_mode_t'(gf)))
            begin
               carry_set_reg[gf] <= carry_in;
               zero_set_reg[gf]  <= zero_in;
            end
         end
      end
   endgenerate

   // view of the active set lags a write by one cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         carry_out <= 1'h0;
         zero_out  <= 1'h0;
      end
      else
      begin
         carry_out <= carry_set_reg[flag_set_sel];
         zero_out  <= zero_set_reg[flag_set_sel];
      end
   end

   // ----------------------------------------------------------------
   // wake-up and low-power gating
   // ----------------------------------------------------------------
   assign status_word = {wake_up, flag_set_sel, nmi_active_reg, irq_active_reg,
                         nmi_latch_reg, req};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wake_up           <= 1'h0;
         low_power_ok      <= 1'h0;
         low_power_refused <= 1'h0;
      end
      else
      begin
         wake_up           <= global_irq_enable & pending_enabled;
         low_power_ok      <= low_power_req & ~pending_enabled;
         low_power_refused <= low_power_req & pending_enabled;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_entry_steps;
      (flag_set_sel != MODE_NORMAL) ##1 stack_push ##1 (irq_active_reg | nmi_active_reg)
      ##2 pc_load;
   endsequence

   property p_entry_order;
      take |-> ##2 s_entry_steps;
   endproperty
   a_entry_order: assert property (p_entry_order)
      else $error("entry steps out of order");

   property p_nmi_vector;
      (pc_load && src_sel_reg == SRC_NMI) |-> pc_vector == `VEC_NMI;
   endproperty
   a_nmi_vector: assert property (p_nmi_vector)
      else $error("nmi vector wrong");

   property p_enable_wake;
      !global_irq_enable |=> !wake_up;
   endproperty
   a_enable_wake: assert property (p_enable_wake)
      else $error("wake-up with global enable cleared");

   property p_no_mask_preempt;
      (irq_active_reg && !accept_nmi) |=> state_reg != ENTRY_FLAGS;
   endproperty
   a_no_mask_preempt: assert property (p_no_mask_preempt)
      else $error("maskable source preempted a routine");

   property p_nmi_preempt;
      (instr_end && state_reg == ENTRY_IDLE && nmi_latch_reg && !nmi_active_reg)
         |=> skip_instr ##1 (flag_set_sel == MODE_NMI);
   endproperty
   a_nmi_preempt: assert property (p_nmi_preempt)
      else $error("nmi not taken");

   property p_priority;
      (take && !accept_nmi && req[0]) |=> src_sel_reg == SRC_1;
   endproperty
   a_priority: assert property (p_priority)
      else $error("source 1 lost priority");

   property p_nmi_clear;
      (clr_step && src_sel_reg == SRC_NMI && !pin_fall[`PIN_NMI]) |=> !nmi_latch_reg;
   endproperty
   a_nmi_clear: assert property (p_nmi_clear)
      else $error("nmi latch not cleared at entry");

   property p_rti;
      (return_from_interrupt && nmi_active_reg && irq_active_reg && state_reg == ENTRY_IDLE)
         |=> (flag_set_sel == MODE_IRQ) && stack_pop && !nmi_active_reg;
   endproperty
   a_rti: assert property (p_rti)
      else $error("return did not restore irq set");

   property p_lp_refuse;
      (low_power_req && pending_enabled) |=> low_power_refused && !low_power_ok;
   endproperty
   a_lp_refuse: assert property (p_lp_refuse)
      else $error("low power granted with request pending");

   property p_edge2;
      (src2_rising_edge_select && pin_rise[`PIN_PC]) |=> edge2_latch_reg;
   endproperty
   a_edge2: assert property (p_edge2)
      else $error("rising edge on source 2 lost");

endmodule : mcu_interrupt_controller
`default_nettype wire

// file: pkg/irq_params.svh
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_OPTION       32'h000000C8
`define ADDR_STATUS       32'h000000CC
`define ADDR_EVT_MASK     32'h000000D0
`define ADDR_EVT_FLAG     32'h000000D4
`define OPTION_RESET      8'h00
`define EVT_RESET         5'h00
`define OPTION_LEVEL_BIT  6
`define OPTION_RISE_BIT   5
`define OPTION_ENABLE_BIT 4
`define HTRANS_ACTIVE_BIT 1

// ----------------------------------------------------------------
// vectors, pins and events
// ----------------------------------------------------------------
`define VEC_NMI     12'hFFC
`define VEC_SRC1    12'hFF6
`define VEC_SRC2    12'hFF4
`define VEC_SRC3    12'hFF2
`define VEC_SRC4    12'hFF0
`define PIN_COUNT   4
`define PIN_NMI     0
`define PIN_PA      1
`define PIN_PB      2
`define PIN_PC      3
`define PIN_IDLE    1'h1
`define EVT_COUNT   5
`define EVT_TMR     0
`define EVT_ADC     1
`define EVT_RT_WRAP 2
`define EVT_RT_CMP  3
`define EVT_RT_CAP  4
`define FLAG_SETS   3

`endif

// file: pkg/irq_pkg.sv
package irq_pkg;

   // entry sequencer steps, one cycle each apart from idle, which holds until a request is taken
   typedef enum {ENTRY_IDLE, ENTRY_FLAGS, ENTRY_PUSH, ENTRY_INHIBIT, ENTRY_CLEAR,
                 ENTRY_VECTOR} entry_state_t;

   // active carry/zero set
   typedef enum logic [1:0] {MODE_NORMAL, MODE_IRQ, MODE_NMI} flag_mode_t;

   // accepted source
   typedef enum logic [2:0] {SRC_NMI, SRC_1, SRC_2, SRC_3, SRC_4} source_t;

endpackage : irq_pkg

// file: design/irq_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_params.svh"
module irq_pin_sync
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level,
   output logic      fall_pulse,
   output logic      rise_pulse
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;
   logic level_reg;
   logic level_next;

   // a change counts only once stages two and three agree
   assign level_next = (stage2_reg == stage3_reg) ? stage3_reg : level_reg;
   assign level      = level_reg;
   assign fall_pulse = level_reg & ~level_next;
   assign rise_pulse = ~level_reg & level_next;

   // idle-high lines reset high so release gives no false edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_reg <= `PIN_IDLE;
         stage2_reg <= `PIN_IDLE;
         stage3_reg <= `PIN_IDLE;
         level_reg  <= `PIN_IDLE;
      end
      else
      begin
         stage1_reg <= pin;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg  <= level_next;
      end
   end

endmodule : irq_pin_sync
`default_nettype wire

// file: tb/irq_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// core stand-in: an instruction ends every fourth cycle
module irq_core_model
(
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      instr_end
);
   logic [1:0] cnt_reg;
   // fixed rate; strobes that land in an entry are ignored by the block
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn) cnt_reg <= 2'h0;
      else cnt_reg <= cnt_reg + 2'h1;
   end
   assign instr_end = (cnt_reg == 2'h3);
endmodule : irq_core_model
`default_nettype wire

// file: tb/tb_mcu_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_params.svh"
module tb_mcu_interrupt_controller
   import irq_pkg::*;
();
   logic        hclk, hresetn, hsel, hwrite, nmi_n, port_a_irq_n, port_b_irq_n;
   logic        flag_wr, carry_in, zero_in, carry_out, zero_out, irq_mode, nmi_mode;
   logic        hresp, skip_instr, stack_push, stack_pop;
   logic [1:0]  skip_hist;
   flag_mode_t  flag_set_sel;
   logic        port_c_irq_n, return_from_interrupt, low_power_req, instr_end;
   logic        hreadyout, pc_load, low_power_ok, low_power_refused, wake_up;
   logic [31:0] haddr, hwdata, hrdata, rd, seed;
   logic [1:0]  htrans;
   logic [4:0]  evt;
   logic [11:0] pc_vector;
   logic [11:0] exp_q[$];
   int          failures, total_checks, n;
   // ------------------------------------------------------------
   // block, core stand-in, clock
   // ------------------------------------------------------------
   mcu_interrupt_controller DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nmi_n,
      .port_a_irq_n, .port_b_irq_n, .port_c_irq_n, .timer_ovf_evt(evt[0]),
      .adc_done_evt(evt[1]), .rt_wrap_evt(evt[2]), .rt_compare_evt(evt[3]),
      .rt_capture_evt(evt[4]), .instr_end, .return_from_interrupt, .low_power_req,
      .flag_wr, .carry_in, .zero_in, .skip_instr, .stack_push,
      .stack_pop, .pc_load, .pc_vector, .flag_set_sel, .irq_mode, .nmi_mode,
      .carry_out, .zero_out, .low_power_ok, .low_power_refused, .wake_up);
   irq_core_model core (.hclk, .hresetn, .instr_end);
   initial
   begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   task check(input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   function logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // data is taken just before the edge, so the update at that edge cannot race it
   task edge_wait;
      n = 0;
      do
      begin
         @(negedge hclk);
         rd = hrdata;
         n++;
      end
      while (hreadyout !== 1'h1 && n < 50);
      check(hresp, 0);
      @(posedge hclk);
      if (n >= 50) check(0, 1);
      if (n >= 50) give_verdict;
   endtask : edge_wait
   task bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      edge_wait;
      htrans <= 2'h0;
      hwdata <= d;
      edge_wait;
   endtask : bus
   task lp(input logic ok);
      @(posedge hclk) low_power_req <= 1;
      @(posedge hclk) low_power_req <= 0;
      @(negedge hclk) check({low_power_ok, low_power_refused, wake_up}, {ok, !ok, !ok});
   endtask : lp
   // note the vector, wait for the load, release the line, clear flags, return
   task enter(input logic [11:0] v);
      exp_q.push_back(v);
      n = 0;
      do
      begin
         @(negedge hclk);
         n++;
      end
      while (pc_load !== 1'h1 && n < 200);
      if (n >= 200) check(0, 1);
      if (n >= 200) give_verdict;
   endtask : enter
   task leave(input logic [31:0] clr);
      @(posedge hclk) {nmi_n, port_a_irq_n, port_c_irq_n} <= 3'h7;
      bus(1, `ADDR_EVT_FLAG, clr);
      @(posedge hclk) return_from_interrupt <= 1;
      @(posedge hclk) return_from_interrupt <= 0;
   endtask : leave
   task serve(input logic [11:0] v, input logic [31:0] clr);
      enter(v);
      leave(clr);
   endtask : serve
   // write the active carry/zero set, read it back once the view has caught up
   task flags(input logic c, z);
      @(posedge hclk) {flag_wr, carry_in, zero_in} <= {1'h1, c, z};
      @(posedge hclk) flag_wr <= 0;
      @(posedge hclk);
      @(negedge hclk) check({carry_out, zero_out}, {c, z});
   endtask : flags
   // skip must lead the push by two cycles
   always @(negedge hclk)
   begin
      skip_hist <= {skip_hist[0], skip_instr};
      if (stack_push === 1'h1) check(skip_hist, 2'h2);
      if (pc_load === 1'h1)
      begin
         if (exp_q.size() == 0) check(1, 0);
         else check(pc_vector, exp_q.pop_front());
      end
   end
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, evt} = 0;
      {nmi_n, port_a_irq_n, port_b_irq_n, port_c_irq_n} = 4'hF;
      {return_from_interrupt, low_power_req, failures, total_checks, n} = 0;
      {flag_wr, carry_in, zero_in} = 0;
      seed = 96428;
      repeat (8) @(posedge hclk);
      hresetn <= 1;
      bus(0, `ADDR_OPTION, 0);
      check(rd, 0);
      bus(0, 32'h100, 0);
      check(rd, 0);
      bus(1, `ADDR_EVT_MASK, 32'h1F);
      bus(0, `ADDR_EVT_MASK, 0);
      check(rd, 32'h1F);
      bus(1, `ADDR_OPTION, (rnd() & 32'hFFFFFF8F) | 32'h40);
      @(posedge hclk) evt <= 5'h06;
      @(posedge hclk) evt <= 0;
      port_a_irq_n <= 0;
      repeat (12) @(posedge hclk);
      lp(1);
      bus(1, `ADDR_OPTION, (rnd() & 32'hFFFFFF8F) | 32'h50);
      lp(0);
      serve(`VEC_SRC1, 0);
      serve(`VEC_SRC3, 32'h04);
      serve(`VEC_SRC4, 32'h02);
      bus(1, `ADDR_OPTION, (rnd() & 32'hFFFFFF8F) | 32'h30);
      repeat (1 + rnd() % 4) @(posedge hclk);
      port_c_irq_n <= 0;
      repeat (6) @(posedge hclk);
      port_c_irq_n <= 1;
      serve(`VEC_SRC2, 0);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge hclk) evt <= 5'h01 << i;
         @(posedge hclk) evt <= 0;
         serve(i < 2 ? `VEC_SRC4 : `VEC_SRC3, 32'h01 << i);
      end
      repeat (1 + rnd() % 4) @(posedge hclk);
      port_b_irq_n <= 0;
      repeat (6) @(posedge hclk);
      port_b_irq_n <= 1;
      serve(`VEC_SRC1, 0);
      flags(1, 0);
      // nmi nested inside a maskable routine, then both returns
      @(posedge hclk) evt <= 5'h02;
      @(posedge hclk) evt <= 0;
      enter(`VEC_SRC4);
      check({irq_mode, nmi_mode, flag_set_sel}, {1'h1, 1'h0, MODE_IRQ});
      flags(0, 1);
      @(posedge hclk) nmi_n <= 0;
      serve(`VEC_NMI, 0);
      @(negedge hclk) check({irq_mode, flag_set_sel, stack_pop}, {1'h1, MODE_IRQ, 1'h1});
      leave(32'h02);
      repeat (2) @(negedge hclk);
      check({carry_out, zero_out}, 2'h2);
      bus(1, `ADDR_OPTION, rnd() & 32'hFFFFFF8F);
      nmi_n <= 0;
      serve(`VEC_NMI, 0);
      repeat (20) @(posedge hclk);
      check(exp_q.size(), 0);
      give_verdict;
   end
endmodule : tb_mcu_interrupt_controller
`default_nettype wire
